// ---- verilog/biw_bank.sv ----
// Purpose: io base/limit window and downstream status register bank
// Assumes: register port and event inputs are on clk_sys_i
// Notes: event inputs are one-cycle pulses from core logic
//        a window with base above limit matches no address
//        offsets other than 1Ch are local to this block
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none

// Operation
// - The low nibble of the io base byte and of the io limit byte always reads 1, meaning 32-bit io decode.
// - Base field bits 7:4 give window bottom address bits 15:12, low twelve bits zero, reset zero.
// - Limit field bits 15:12 give window top address bits 15:12, low twelve bits all ones, reset zero.
// - Window address bits 31:16 of bottom and top come from a separate upper-half register.
// - The decoded window decides whether an io request is forwarded to the other side.
// - Status bits 21, 23 and 26:25 read zero; bits 20:16 and 22 are reserved, read zero, writes kept out.
// - Bit 24 sets on a downstream parity error only while parity response is enabled; write one clears it.
// - Bit 27 sets when the port completes a downstream request with completer abort; cleared only by reset.
// - Bit 29 sets when an unsupported request completion is received downstream; cleared only by reset.
// - Bit 30 sets when an error message is sent while the system error enable is on; write one clears it.
// - Bit 31 sets whenever a poisoned packet is received downstream; write one clears it.
module biw_bank
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [biw_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic [biw_pkg::DATA_W-1:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [biw_pkg::DATA_W-1:0] reg_rdata_o,
    // downstream event pulses
    input wire logic ev_parity_err_i,
    input wire logic ev_ca_sent_i,
    input wire logic ev_ca_rcvd_i,
    input wire logic ev_ur_rcvd_i,
    input wire logic ev_err_msg_sent_i,
    input wire logic ev_poison_rcvd_i,
    // io request to be steered
    input wire logic io_req_i,
    input wire logic io_from_up_i,
    input wire logic [31:0] io_addr_i,
    // forwarding decision
    output logic io_dec_valid_o,
    output logic io_hit_o,
    output logic io_fwd_o,
    // interrupt
    output logic irq_o
);
    // sticky next value: a set in the clearing cycle is kept
    function automatic logic [5:0] sticky_next
    (
        input logic [5:0] cur,
        input logic [5:0] set,
        input logic [5:0] clr
    );
        sticky_next = set | (cur & ~clr);
    endfunction : sticky_next

    // write strobe decode for one register offset
    function automatic logic wr_hit
    (
        input logic wr,
        input logic [7:0] addr,
        input logic [7:0] off
    );
        wr_hit = wr && (addr == off);
    endfunction : wr_hit

    // registers
    logic [3:0] base_fld_q;
    logic [3:0] limit_fld_q;
    logic [15:0] base_up_q;
    logic [15:0] limit_up_q;
    logic [1:0] ctrl_q;
    logic [5:0] st_q;
    logic [5:0] st_d;
    logic [5:0] irq_st_q;
    logic [5:0] irq_st_d;
    logic [5:0] irq_mask_q;
    logic [31:0] rdata_q;
    logic irq_q;

    // combinational terms
    logic [5:0] ev_set;
    logic [5:0] st_clr;
    logic [5:0] irq_clr;
    logic [31:0] io_word;
    logic [31:0] rd_mux;
    logic wr_io;
    logic wr_up;
    logic wr_ctrl;
    logic wr_ist;
    logic wr_imask;
    logic perr_en;
    logic serr_en;
    logic irq_pend;

    // window carrier
    biw_win_if win ();

    // write decode
    assign wr_io = wr_hit(reg_wr_i, reg_addr_i, biw_pkg::OFF_IO_STAT);
    assign wr_up = wr_hit(reg_wr_i, reg_addr_i, biw_pkg::OFF_IO_UPPER);
    assign wr_ctrl = wr_hit(reg_wr_i, reg_addr_i, biw_pkg::OFF_CTRL);
    assign wr_ist = wr_hit(reg_wr_i, reg_addr_i, biw_pkg::OFF_IRQ_STAT);
    assign wr_imask = wr_hit(reg_wr_i, reg_addr_i, biw_pkg::OFF_IRQ_MASK);

    // io base field; indicator nibbles are not stored
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            base_fld_q <= biw_pkg::IO_FIELD_RST;
        end
        else if (wr_io)
        begin
            base_fld_q <= reg_wdata_i[biw_pkg::IO_BASE_LSB +: 4];
        end
    end

    // io limit field, written by the same word as the base
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            limit_fld_q <= biw_pkg::IO_FIELD_RST;
        end
        else if (wr_io)
        begin
            limit_fld_q <= reg_wdata_i[biw_pkg::IO_LIMIT_LSB +: 4];
        end
    end

    // upper half of window bottom
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            base_up_q <= biw_pkg::IO_UPPER_RST;
        end
        else if (wr_up)
        begin
            base_up_q <= reg_wdata_i[biw_pkg::UP_BASE_LSB +: 16];
        end
    end

    // upper half of window top, shares its word with the bottom half
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            limit_up_q <= biw_pkg::IO_UPPER_RST;
        end
        else if (wr_up)
        begin
            limit_up_q <= reg_wdata_i[biw_pkg::UP_LIMIT_LSB +: 16];
        end
    end

    // parity response and system error enables
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            ctrl_q <= biw_pkg::CTRL_RST;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= reg_wdata_i[biw_pkg::CTRL_SERR_EN:biw_pkg::CTRL_PERR_EN];
        end
    end

    // named enable taps keep the event gating readable
    assign perr_en = ctrl_q[biw_pkg::CTRL_PERR_EN];
    assign serr_en = ctrl_q[biw_pkg::CTRL_SERR_EN];

    // decoded window bounds
    assign win.base = {base_up_q, base_fld_q, biw_pkg::IO_BASE_FILL};
    assign win.limit = {limit_up_q, limit_fld_q, biw_pkg::IO_LIMIT_FILL};

    // request passed on unregistered; the decoder adds the one cycle
    assign win.addr = io_addr_i;
    assign win.req = io_req_i;
    assign win.from_up = io_from_up_i;

    // forwarding decision, registered inside the decoder
    biw_io_window_dec u_dec
    (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .win(win.dec)
    );

    // qualified events; the enables gate setting, not clearing
    always_comb
    begin
        ev_set = 6'h00;
        ev_set[biw_pkg::EV_PERR] = ev_parity_err_i & perr_en;
        ev_set[biw_pkg::EV_CA_SENT] = ev_ca_sent_i;
        ev_set[biw_pkg::EV_CA_RCVD] = ev_ca_rcvd_i;
        ev_set[biw_pkg::EV_UR_RCVD] = ev_ur_rcvd_i;
        ev_set[biw_pkg::EV_SERR] = ev_err_msg_sent_i & serr_en;
        ev_set[biw_pkg::EV_POISON] = ev_poison_rcvd_i;
    end

    // clear mask from the 1Ch write; read-only bits are masked off
    always_comb
    begin
        st_clr = 6'h00;
        if (wr_io)
        begin
            st_clr[biw_pkg::EV_PERR] = reg_wdata_i[biw_pkg::ST_PERR];
            st_clr[biw_pkg::EV_CA_SENT] = reg_wdata_i[biw_pkg::ST_CA_SENT];
            st_clr[biw_pkg::EV_CA_RCVD] = reg_wdata_i[biw_pkg::ST_CA_RCVD];
            st_clr[biw_pkg::EV_UR_RCVD] = reg_wdata_i[biw_pkg::ST_UR_RCVD];
            st_clr[biw_pkg::EV_SERR] = reg_wdata_i[biw_pkg::ST_SERR];
            st_clr[biw_pkg::EV_POISON] = reg_wdata_i[biw_pkg::ST_POISON];
            st_clr = st_clr & biw_pkg::EV_W1C_MASK;
        end
    end

    // downstream status bits
    assign st_d = sticky_next(st_q, ev_set, st_clr);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            st_q <= biw_pkg::EV_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // interrupt status mirrors every qualified event and is always clearable
    always_comb
    begin
        irq_clr = biw_pkg::EV_RST;
        if (wr_ist)
        begin
            irq_clr = reg_wdata_i[biw_pkg::N_EV-1:0];
        end
    end

    assign irq_st_d = sticky_next(irq_st_q, ev_set, irq_clr);

    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            irq_st_q <= biw_pkg::EV_RST;
        end
        else
        begin
            irq_st_q <= irq_st_d;
        end
    end

    // interrupt mask, one enables the matching status bit
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            irq_mask_q <= biw_pkg::EV_RST;
        end
        else if (wr_imask)
        begin
            irq_mask_q <= reg_wdata_i[biw_pkg::N_EV-1:0];
        end
    end

    // pending term from next-state status, so irq_o rises with the status bit
    assign irq_pend = |(irq_st_d & irq_mask_q);

    // level interrupt straight from a flop; a mask write acts one cycle late
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            irq_q <= 1'b0;
        end
        else
        begin
            irq_q <= irq_pend;
        end
    end

    // word at 1Ch; unset bits stay zero, covering hardwired and reserved
    always_comb
    begin
        io_word = 32'h0000_0000;
        io_word[biw_pkg::IO_BASE_IND_LSB +: 4] = biw_pkg::IO_DEC32_IND;
        io_word[biw_pkg::IO_BASE_LSB +: 4] = base_fld_q;
        io_word[biw_pkg::IO_LIMIT_IND_LSB +: 4] = biw_pkg::IO_DEC32_IND;
        io_word[biw_pkg::IO_LIMIT_LSB +: 4] = limit_fld_q;
        io_word[biw_pkg::ST_PERR] = st_q[biw_pkg::EV_PERR];
        io_word[biw_pkg::ST_CA_SENT] = st_q[biw_pkg::EV_CA_SENT];
        io_word[biw_pkg::ST_CA_RCVD] = st_q[biw_pkg::EV_CA_RCVD];
        io_word[biw_pkg::ST_UR_RCVD] = st_q[biw_pkg::EV_UR_RCVD];
        io_word[biw_pkg::ST_SERR] = st_q[biw_pkg::EV_SERR];
        io_word[biw_pkg::ST_POISON] = st_q[biw_pkg::EV_POISON];
    end

    // read select; unmapped offsets read zero
    always_comb
    begin
        case (reg_addr_i)
            biw_pkg::OFF_IO_STAT: rd_mux = io_word;
            biw_pkg::OFF_IO_UPPER: rd_mux = {limit_up_q, base_up_q};
            biw_pkg::OFF_CTRL: rd_mux = {30'h0, ctrl_q};
            biw_pkg::OFF_IRQ_STAT: rd_mux = {26'h0, irq_st_q};
            biw_pkg::OFF_IRQ_MASK: rd_mux = {26'h0, irq_mask_q};
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (reg_rd_i)
        begin
            rdata_q <= rd_mux;
        end
        else
        begin
            rdata_q <= 32'h0000_0000;
        end
    end

    // outputs
    assign reg_rdata_o = rdata_q;
    assign irq_o = irq_q;
    assign io_dec_valid_o = win.fwd_valid;
    assign io_hit_o = win.hit;
    assign io_fwd_o = win.fwd;
endmodule : biw_bank
`default_nettype wire

// ---- verilog/biw_pkg.sv ----
// Purpose: constants for the bridge I/O window and downstream status bank
// Assumes: 32-bit register port with 8-bit byte addresses
// Notes: io and status field positions are bit numbers within the 32-bit word at 1Ch
package biw_pkg;
    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // byte offsets of the registers
    localparam logic [7:0] OFF_IO_STAT = 8'h1C;
    localparam logic [7:0] OFF_IO_UPPER = 8'h30;
    localparam logic [7:0] OFF_CTRL = 8'h40;
    localparam logic [7:0] OFF_IRQ_STAT = 8'h44;
    localparam logic [7:0] OFF_IRQ_MASK = 8'h48;

    // io base and limit byte layout
    localparam int IO_BASE_IND_LSB = 0;
    localparam int IO_BASE_LSB = 4;
    localparam int IO_LIMIT_IND_LSB = 8;
    localparam int IO_LIMIT_LSB = 12;
    localparam logic [3:0] IO_DEC32_IND = 4'h1;
    localparam logic [3:0] IO_FIELD_RST = 4'h0;
    localparam logic [11:0] IO_BASE_FILL = 12'h000;
    localparam logic [11:0] IO_LIMIT_FILL = 12'hFFF;
    localparam logic [15:0] IO_UPPER_RST = 16'h0000;

    // upper-half register layout
    localparam int UP_BASE_LSB = 0;
    localparam int UP_LIMIT_LSB = 16;

    // downstream status bit positions
    localparam int ST_PERR = 24;
    localparam int ST_CA_SENT = 27;
    localparam int ST_CA_RCVD = 28;
    localparam int ST_UR_RCVD = 29;
    localparam int ST_SERR = 30;
    localparam int ST_POISON = 31;

    // event index, shared by status and interrupt bits
    localparam int N_EV = 6;
    localparam int EV_PERR = 0;
    localparam int EV_CA_SENT = 1;
    localparam int EV_CA_RCVD = 2;
    localparam int EV_UR_RCVD = 3;
    localparam int EV_SERR = 4;
    localparam int EV_POISON = 5;
    localparam logic [5:0] EV_W1C_MASK = 6'h31;
    localparam logic [5:0] EV_RST = 6'h00;

    // control register bits
    localparam int CTRL_PERR_EN = 0;
    localparam int CTRL_SERR_EN = 1;
    localparam logic [1:0] CTRL_RST = 2'h0;
endpackage : biw_pkg

// ---- verilog/biw_win_if.sv ----
// Purpose: carrier between register bank and io window decoder
// Assumes: single clock domain
// Notes: bank drives bounds and request, decoder returns forward decision
`timescale 1ns/1ns
`default_nettype none
interface biw_win_if;
    logic [31:0] base;
    logic [31:0] limit;
    logic [31:0] addr;
    logic req;
    logic from_up;
    logic fwd_valid;
    logic fwd;
    logic hit;
    modport bank (output base, limit, addr, req, from_up, input fwd_valid, fwd, hit);
    modport dec (input base, limit, addr, req, from_up, output fwd_valid, fwd, hit);
endinterface : biw_win_if
`default_nettype wire

// ---- verilog/biw_io_window_dec.sv ----
// Purpose: io window hit test and forwarding decision
// Assumes: bounds are stable while requests are presented
// Notes: one cycle from request to registered decision
`timescale 1ns/1ns
`default_nettype none
module biw_io_window_dec
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // window carrier
    biw_win_if.dec win
);
    logic hit_now;

    // inclusive on both ends; base above limit gives an empty window
    assign hit_now = (win.addr >= win.base) && (win.addr <= win.limit);

    // downstream-bound inside goes down, upstream-bound outside goes up
    always_ff @(posedge clk_sys_i)
    begin
        if (rst_i)
        begin
            win.fwd_valid <= 1'b0;
            win.fwd <= 1'b0;
            win.hit <= 1'b0;
        end
        else
        begin
            win.fwd_valid <= win.req;
            win.hit <= win.req & hit_now;
            win.fwd <= win.req & (win.from_up ? hit_now : ~hit_now);
        end
    end
endmodule : biw_io_window_dec
`default_nettype wire

// ---- bench/biw_bank_checker.sv ----
// Purpose: port-level assertions for the io window and status bank
// Assumes: single clock, synchronous active-high reset
// Notes: status is only visible through reads, so set checks go via reads
`timescale 1ns/1ns
`default_nettype none
module biw_bank_checker
(
    // clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // register port
    input wire logic [biw_pkg::ADDR_W-1:0] reg_addr_i,
    input wire logic reg_rd_i,
    input wire logic reg_wr_i,
    input wire logic [biw_pkg::DATA_W-1:0] reg_rdata_o,
    // events
    input wire logic ev_ca_sent_i,
    input wire logic ev_poison_rcvd_i,
    // io decode
    input wire logic io_req_i,
    input wire logic io_from_up_i,
    input wire logic io_dec_valid_o,
    input wire logic io_hit_o,
    input wire logic io_fwd_o
);
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (rst_i);
    // read qualifiers
    wire rd_1c = reg_rd_i && (reg_addr_i == biw_pkg::OFF_IO_STAT);
    wire rd_bad = reg_rd_i && !(reg_addr_i inside {8'h1C, 8'h30, 8'h40, 8'h44, 8'h48});
    // an abort bit can only clear by reset, so any later read sees it
    sequence s_abort_read;
        ev_ca_sent_i ##[1:4] rd_1c;
    endsequence
    // poison bit is clearable, so no write may come between
    sequence s_poison_read;
        ev_poison_rcvd_i ##1 (!reg_wr_i throughout ##[0:3] rd_1c);
    endsequence
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 32'h0)
        else $error("read data not zero outside a read");
    a_unmapped_zero: assert property (rd_bad |=> reg_rdata_o == 32'h0)
        else $error("unmapped read returned data");
    a_fixed_ind: assert property (rd_1c |=> reg_rdata_o[3:0] == 4'h1 && reg_rdata_o[11:8] == 4'h1)
        else $error("decode indicator nibble wrong");
    a_hard_zero: assert property (rd_1c |=> reg_rdata_o[23:16] == 8'h00 && reg_rdata_o[26:25] == 2'h0)
        else $error("hardwired status bits not zero");
    a_dec_answer: assert property (io_req_i |=> io_dec_valid_o)
        else $error("no decision after io request");
    a_dec_quiet: assert property (!io_req_i |=> !io_dec_valid_o && !io_hit_o && !io_fwd_o)
        else $error("decision outputs without request");
    a_fwd_rule: assert property (io_dec_valid_o |-> io_fwd_o == ($past(io_from_up_i) ? io_hit_o : !io_hit_o))
        else $error("forward does not follow hit and side");
    a_abort_seen: assert property (s_abort_read |=> reg_rdata_o[27])
        else $error("abort sent bit not set");
    a_poison_seen: assert property (s_poison_read |=> reg_rdata_o[31])
        else $error("poison bit not set");
endmodule : biw_bank_checker
bind biw_bank biw_bank_checker u_chk (.clk_sys_i, .rst_i, .reg_addr_i, .reg_rd_i, .reg_wr_i,
    .reg_rdata_o, .ev_ca_sent_i, .ev_poison_rcvd_i, .io_req_i, .io_from_up_i, .io_dec_valid_o,
    .io_hit_o, .io_fwd_o);
`default_nettype wire

// ---- bench/biw_bank_bench.sv ----
// Purpose: directed bench for the io window and downstream status bank
// Assumes: 10 MHz clock, read data checked the cycle after the strobe
// Notes: window fields left at F/F after the fixed-bit test until the mid-run reset
`timescale 1ns/1ns
`default_nettype none
module biw_bank_bench;
    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [5:0] ev = 6'h00;
    logic req = 1'b0;
    logic from_up = 1'b0;
    logic [31:0] io_addr = 32'h0;
    logic [31:0] rdata;
    logic dec_valid;
    logic hit;
    logic fwd;
    logic irq;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    // clock
    always #50 clk_sys_i = ~clk_sys_i;
    biw_bank dut (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .reg_addr_i(addr), .reg_wdata_i(wdata),
        .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .ev_parity_err_i(ev[0]),
        .ev_ca_sent_i(ev[1]), .ev_ca_rcvd_i(ev[2]), .ev_ur_rcvd_i(ev[3]),
        .ev_err_msg_sent_i(ev[4]), .ev_poison_rcvd_i(ev[5]), .io_req_i(req),
        .io_from_up_i(from_up), .io_addr_i(io_addr), .io_dec_valid_o(dec_valid),
        .io_hit_o(hit), .io_fwd_o(fwd), .irq_o(irq));
    // register read data
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp
    // decision triple: valid, hit, forward
    task automatic cmp_dec(input logic [2:0] got, input logic [2:0] exp);
        checked++;
        if (got !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t dec got=%h exp=%h", $time, got, exp);
        end
    endtask : cmp_dec
    // interrupt level
    task automatic cmp_irq(input logic exp);
        checked++;
        if (irq !== exp)
        begin
            fail_count++;
            $display("BAD t=%0t irq got=%h exp=%h", $time, irq, exp);
        end
    endtask : cmp_irq
    // write, optionally with event pulses in the same cycle
    task automatic put(input logic [7:0] a, input logic [31:0] d, input logic [5:0] e = 6'h00);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        ev <= e;
        @(posedge clk_sys_i);
        wr <= 1'b0;
        ev <= 6'h00;
    endtask : put
    task automatic get(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 cmp(rdata, exp);
    endtask : get
    // one io request, decision looked at in its single valid cycle
    task automatic io(input logic [31:0] a, input logic up, input logic h);
        @(posedge clk_sys_i);
        req <= 1'b1;
        io_addr <= a;
        from_up <= up;
        @(posedge clk_sys_i);
        req <= 1'b0;
        #1 cmp_dec({dec_valid, hit, fwd}, {1'b1, h, up ? h : !h});
    endtask : io
    task automatic wrap_up();
        $display("mismatches %0d comparisons %0d", fail_count, checked);
        if (fail_count == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : wrap_up
    // hang guard, the sequence needs well under 400 cycles
    always @(posedge clk_sys_i)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            fail_count++;
            wrap_up();
        end
    end
    initial
    begin
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        get(8'h1C, 32'h0000_0101);
        get(8'h30, 32'h0);
        get(8'h40, 32'h0);
        get(8'h44, 32'h0);
        get(8'h48, 32'h0);
        get(8'h50, 32'h0);
        cmp_irq(1'b0);
        put(8'h1C, 32'h06FF_FFFF);
        get(8'h1C, 32'h0000_F1F1);
        // gated events must leave no trace
        pulse_gated: put(8'h50, 32'h0, 6'h11);
        get(8'h1C, 32'h0000_F1F1);
        get(8'h44, 32'h0);
        put(8'h48, 32'h3F);
        get(8'h48, 32'h3F);
        put(8'h40, 32'h3);
        get(8'h40, 32'h3);
        put(8'h50, 32'h0, 6'h3F);
        get(8'h1C, 32'hF900_F1F1);
        get(8'h44, 32'h3F);
        cmp_irq(1'b1);
        // clear racing a fresh poison event
        put(8'h1C, 32'hC100_F1F1, 6'h20);
        get(8'h1C, 32'hB800_F1F1);
        put(8'h1C, 32'h0000_F1F1);
        get(8'h1C, 32'hB800_F1F1);
        put(8'h1C, 32'hFF00_F1F1);
        get(8'h1C, 32'h3800_F1F1);
        // masking of the interrupt
        put(8'h48, 32'h00);
        put(8'h44, 32'h3F);
        get(8'h44, 32'h0);
        cmp_irq(1'b0);
        put(8'h50, 32'h0, 6'h08);
        get(8'h44, 32'h08);
        cmp_irq(1'b0);
        put(8'h48, 32'h08);
        get(8'h48, 32'h08);
        cmp_irq(1'b1);
        // mid-run reset must clear the abort bits, mask and interrupt
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        get(8'h1C, 32'h0000_0101);
        get(8'h44, 32'h0);
        get(8'h48, 32'h0);
        cmp_irq(1'b0);
        // window edges from both sides
        put(8'h30, 32'h0002_0001);
        get(8'h30, 32'h0002_0001);
        put(8'h1C, 32'h0000_5030);
        get(8'h1C, 32'h0000_5131);
        for (int u = 0; u < 2; u++)
        begin
            io(32'h0001_2FFF, u[0], 1'b0);
            io(32'h0001_3000, u[0], 1'b1);
            io(32'h0002_5FFF, u[0], 1'b1);
            io(32'h0002_6000, u[0], 1'b0);
            io(32'h0000_3000, u[0], 1'b0);
        end
        wrap_up();
    end
endmodule : biw_bank_bench
`default_nettype wire
